// *** design/pwm_pkg.sv ***
/*
 * shared constants for the grayscale pwm latch block.
 * assumes nothing beyond a systemverilog tool flow.
 */
package pwm_pkg;
   // frame and slot geometry
   localparam int GS_BITS = 288;
   localparam int GS_VAL_W = 12;
   localparam int CNT_W = 13;
   localparam int CH_N = 8;
   localparam int SLOT_STRIDE = 36;
   localparam int BLUE_BASE = 24;
   localparam int RED_BASE = 0;
   localparam int FBD_W = 205;
   // function latch fields
   localparam int MODE_HI_BIT = 198;
   localparam int MODE_LO_BIT = 197;
   localparam int BC_W = 8;
   localparam int BC_BLUE_LSB = 184;
   localparam int BC_RED_LSB = 168;
   // reset values
   localparam logic [GS_BITS-1:0] GS_RESET = '0;
   localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;
   // counter end points per mode, one past the last value
   localparam logic [CNT_W-1:0] END_12 = 13'h1000;
   localparam logic [CNT_W-1:0] END_10 = 13'h0400;
   localparam logic [CNT_W-1:0] END_8 = 13'h0100;
   localparam logic [GS_VAL_W-1:0] MASK_12 = 12'hfff;
   localparam logic [GS_VAL_W-1:0] MASK_10 = 12'h3ff;
   localparam logic [GS_VAL_W-1:0] MASK_8 = 12'h0ff;
   typedef enum logic [1:0] {
      MODE_12, MODE_10, MODE_8
   } count_mode_t;
endpackage

// *** design/count_if.sv ***
/*
 * carries the shared counter value and value mask to the comparators.
 * assumes one clock domain on both ends.
 */
`timescale 1ns/1ps
interface count_if;
   import pwm_pkg::*;
   logic [CNT_W-1:0] count;
   logic [GS_VAL_W-1:0] mask;
   modport cnt (output count, output mask);
   modport cmp (input count, input mask);
endinterface

// *** design/gs_counter.sv ***
/*
 * shared grayscale counter, gated by the output gate.
 * assumes gate and reference-clock edges arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
module gs_counter
   import pwm_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic gate_in,
   input wire logic gate_fall_in,
   input wire logic pwm_reference_clock_rise_in,
   input wire logic [1:0] width_sel_in,
   count_if.cnt bus
);
   count_mode_t mode;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [CNT_W-1:0] cnt_end;
   logic at_end;

   // upper select bit low means full width
   assign mode = !width_sel_in[1] ? MODE_12 :
                 (width_sel_in[0] ? MODE_8 : MODE_10);
   assign cnt_end = (mode == MODE_10) ? END_10 :
                    (mode == MODE_8) ? END_8 : END_12;
   assign bus.mask = (mode == MODE_10) ? MASK_10 :
                     (mode == MODE_8) ? MASK_8 : MASK_12;
   // saturate one past the top so every channel ends off
   assign at_end = (cnt_r >= cnt_end);
   assign cnt_nxt = (gate_fall_in || !gate_in) ? CNT_RESET :
                    (pwm_reference_clock_rise_in && !at_end) ? cnt_r + 13'h0001 :
                    cnt_r;

   // counter register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign bus.count = cnt_r;
endmodule // gs_counter

// *** design/sink_compare.sv ***
/*
 * per-channel on/off decision against the shared counter.
 * assumes the latch values are stable between load strobes.
 */
`timescale 1ns/1ps
module sink_compare
   import pwm_pkg::*;
#(
   parameter int N = CH_N
)
(
   input wire logic [N*GS_VAL_W-1:0] values_in,
   count_if.cmp bus,
   output logic [N-1:0] on_out
);
   genvar i;
   // on from count 1 up to and including the value
   generate
      for (i = 0; i < N; i++) begin : g_ch
         logic [GS_VAL_W-1:0] v;
         assign v = values_in[i*GS_VAL_W +: GS_VAL_W] & bus.mask;
         assign on_out[i] = (bus.count != CNT_RESET) &&
                            (bus.count <= {1'b0, v});
      end
   endgenerate
endmodule // sink_compare

// *** design/grayscale_pwm_latch.sv ***
/*
 * grayscale pwm generator: common shift register, grayscale latch,
 * shared counter and sixteen sink outputs.
 * assumes all pins are synchronous to ref_clk_in, which runs well
 * above the serial and reference clock rates, so that every pin level
 * stands for at least two system clocks.
 * assumes the function latch contents arrive on a port; their own
 * write path lives outside this block.
 * limitation: a shift edge that lands in the same cycle as a load
 * edge is lost, since the load takes the shift register.
 */
`timescale 1ns/1ps
module grayscale_pwm_latch
   import pwm_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   input wire logic load_in,
   input wire logic pwm_reference_clock_in,
   input wire logic gate_in,
   input wire logic [FBD_W-1:0] function_latch_in,
   output logic serial_out,
   output logic [CH_N-1:0] blue_sink_n_out,
   output logic [CH_N-1:0] red_sink_n_out,
   output logic [BC_W-1:0] blue_ratio_out,
   output logic [BC_W-1:0] red_ratio_out,
   output logic [GS_BITS-1:0] grayscale_latch_out
);

   // ****************************************
   // input sampling and edge detection
   // ****************************************

   logic sclk_r;
   logic load_r;
   logic pwm_reference_clock_r;
   logic gate_r;
   logic sclk_d_r;
   logic load_d_r;
   logic pwm_reference_clock_d_r;
   logic gate_d_r;
   logic sclk_rise;
   logic load_rise;
   logic pwm_reference_clock_rise;
   logic gate_fall;
   logic sdata_r;

   // one register stage, then a delayed copy for edges
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_r <= 1'b0;
         load_r <= 1'b0;
         pwm_reference_clock_r <= 1'b0;
         gate_r <= 1'b0;
      end else begin
         sclk_r <= serial_clk_in;
         load_r <= load_in;
         pwm_reference_clock_r <= pwm_reference_clock_in;
         gate_r <= gate_in;
      end
   end

   // the data pin gets the same single stage, so it lines up with the
   // sampled shift clock and is taken on the detected edge
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sdata_r <= 1'b0;
      end else begin
         sdata_r <= serial_data_in;
      end
   end

   // previous values, so each edge becomes a single pulse
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_d_r <= 1'b0;
         load_d_r <= 1'b0;
         pwm_reference_clock_d_r <= 1'b0;
         gate_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_r;
         load_d_r <= load_r;
         pwm_reference_clock_d_r <= pwm_reference_clock_r;
         gate_d_r <= gate_r;
      end
   end

   // edge helpers; one shared pair keeps all detectors alike, and the
   // reset value of each delayed copy matches the idle low pin level
   function automatic logic rise_of(input logic cur, input logic prev);
      rise_of = cur & ~prev;
   endfunction

   function automatic logic fall_of(input logic cur, input logic prev);
      fall_of = ~cur & prev;
   endfunction

   // edge pulses; every edge is seen on the one system clock, so the
   // reference clock and gate reach the counter without a raw crossing
   assign sclk_rise = rise_of(sclk_r, sclk_d_r);
   assign load_rise = rise_of(load_r, load_d_r);
   assign pwm_reference_clock_rise = rise_of(pwm_reference_clock_r, pwm_reference_clock_d_r);
   assign gate_fall = fall_of(gate_r, gate_d_r);

   // ****************************************
   // common shift register and grayscale latch
   // ****************************************

   logic [GS_BITS-1:0] shift_r;
   logic [GS_BITS-1:0] shift_nxt;
   logic [GS_BITS-1:0] latch_r;
   logic [GS_BITS-1:0] latch_nxt;
   logic [GS_BITS-1:0] shifted;
   logic [GS_BITS-1:0] reloaded;

   // data enters at the bottom and leaves at the top
   assign shifted = {shift_r[GS_BITS-2:0], sdata_r};
   // after a load the function latch sits in the low bits
   assign reloaded = {shift_r[GS_BITS-1:FBD_W],
                      function_latch_in};
   // load wins over a shift edge in the same cycle; the host must not
   // clock data on the strobe edge anyway
   assign shift_nxt = load_rise ? reloaded :
                      sclk_rise ? shifted : shift_r;
   assign latch_nxt = load_rise ? shift_r : latch_r;

   // shift register and latch, both cleared by reset
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         shift_r <= GS_RESET;
         latch_r <= GS_RESET;
      end else begin
         shift_r <= shift_nxt;
         latch_r <= latch_nxt;
      end
   end

   // ****************************************
   // slot extraction
   // ****************************************

   // pull one 12-bit slot from the frame at a given base bit
   function automatic logic [GS_VAL_W-1:0] slot_of(
      input logic [GS_BITS-1:0] frame,
      input int base
   );
      slot_of = frame[base +: GS_VAL_W];
   endfunction

   logic [CH_N*GS_VAL_W-1:0] blue_vals;
   logic [CH_N*GS_VAL_W-1:0] red_vals;
   genvar k;

   // blue k at 36k+24, red k at 36k; reserved slot between them.
   // the reserved slots are carried in the latch and read back, but
   // no output decodes them; blue 7 sits at the very top and red 0 at
   // the very bottom of the frame
   generate
      for (k = 0; k < CH_N; k++) begin : g_slot
         assign blue_vals[k*GS_VAL_W +: GS_VAL_W] =
            slot_of(latch_r, k*SLOT_STRIDE + BLUE_BASE);
         assign red_vals[k*GS_VAL_W +: GS_VAL_W] =
            slot_of(latch_r, k*SLOT_STRIDE + RED_BASE);
      end
   endgenerate

   // ****************************************
   // function latch field decode
   // ****************************************

   logic [1:0] width_sel;
   logic [BC_W-1:0] blue_code;
   logic [BC_W-1:0] red_code;

   // width select is read live, so a mode change acts on the very next
   // count; the host should only change it with the gate low
   assign width_sel = function_latch_in[MODE_HI_BIT:MODE_LO_BIT];
   // group brightness codes for the two colour groups
   assign blue_code = function_latch_in[BC_BLUE_LSB +: BC_W];
   assign red_code = function_latch_in[BC_RED_LSB +: BC_W];

   // ****************************************
   // shared counter and channel compare
   // ****************************************

   count_if cbus ();
   logic [CH_N-1:0] blue_on;
   logic [CH_N-1:0] red_on;

   gs_counter u_counter (
      .clk_in(ref_clk_in),
      .rst_in(rst_in),
      .gate_in(gate_r),
      .gate_fall_in(gate_fall),
      .pwm_reference_clock_rise_in(pwm_reference_clock_rise),
      .width_sel_in(width_sel),
      .bus(cbus.cnt)
   );

   // compare uses the live latch, so a load shows up at once
   sink_compare #(.N(CH_N)) u_blue (
      .values_in(blue_vals),
      .bus(cbus.cmp),
      .on_out(blue_on)
   );

   sink_compare #(.N(CH_N)) u_red (
      .values_in(red_vals),
      .bus(cbus.cmp),
      .on_out(red_on)
   );

   // ****************************************
   // registered outputs
   // ****************************************

   // sinks lag the counter by one system clock, far below one
   // reference period; gate low forces them off
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         blue_sink_n_out <= '0;
      end else begin
         blue_sink_n_out <= blue_on & {CH_N{gate_r}};
      end
   end

   // red group, same timing as blue so both colours switch together
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         red_sink_n_out <= '0;
      end else begin
         red_sink_n_out <= red_on & {CH_N{gate_r}};
      end
   end

   // the current ratio is the group code itself, code/255 of full
   // scale; the analog stage applies it
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         blue_ratio_out <= '0;
      end else begin
         blue_ratio_out <= blue_code;
      end
   end

   // red group code; kept separate so each group can be
   // retimed on its own if the analog stage asks for it
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         red_ratio_out <= '0;
      end else begin
         red_ratio_out <= red_code;
      end
   end

   // serial output follows the next top bit, so the pin changes on
   // the same edge as the shift register itself
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= shift_nxt[GS_BITS-1];
      end
   end

   // latch readback copies the next latch value, which keeps it in
   // step with the latch instead of one cycle behind
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         grayscale_latch_out <= GS_RESET;
      end else begin
         grayscale_latch_out <= latch_nxt;
      end
   end

endmodule // grayscale_pwm_latch

// *** sim/grayscale_pwm_latch_sva.sv ***
/* port assertions for grayscale_pwm_latch.
   assumes inputs are sampled twice before an edge acts. */
`timescale 1ns/1ps
module grayscale_pwm_latch_sva
   import pwm_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic serial_clk_in,
   input wire logic load_in,
   input wire logic pwm_reference_clock_in,
   input wire logic gate_in,
   input wire logic [FBD_W-1:0] function_latch_in,
   input wire logic serial_out,
   input wire logic [CH_N-1:0] blue_sink_n_out,
   input wire logic [CH_N-1:0] red_sink_n_out,
   input wire logic [BC_W-1:0] blue_ratio_out,
   input wire logic [BC_W-1:0] red_ratio_out,
   input wire logic [GS_BITS-1:0] grayscale_latch_out
);
   // ****
   // edge causes, gate, ratios and reset
   // ****
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   wire logic on_w = |{blue_sink_n_out, red_sink_n_out};
   sequence ld2;
      $past(load_in, 2) && !$past(load_in, 3);
   endsequence
   sequence ld3;
      $past(load_in, 3) && !$past(load_in, 4);
   endsequence
   sequence gc3;
      $past(pwm_reference_clock_in, 3) &&
         !$past(pwm_reference_clock_in, 4);
   endsequence
   a_latch_on_load:
      assert property ($changed(grayscale_latch_out) |-> ld2)
      else $error("latch moved without load");
   a_serial_on_shift:
      assert property ($changed(serial_out) |->
         $past(serial_clk_in, 2) && !$past(serial_clk_in, 3))
      else $error("serial out moved without shift");
   a_sink_on_cause:
      assert property ($rose(on_w) |-> gc3 or ld3)
      else $error("sink on without cause");
   a_sink_needs_gate:
      assert property (on_w |-> $past(gate_in, 3))
      else $error("sink on with gate low");
   a_gate_low_off:
      assert property (!gate_in [*4] |-> !on_w)
      else $error("sink on after gate fall");
   a_blue_ratio:
      assert property ($stable(function_latch_in) [*3] |->
         blue_ratio_out == function_latch_in[BC_BLUE_LSB +: BC_W])
      else $error("blue ratio wrong");
   a_red_ratio:
      assert property ($stable(function_latch_in) [*3] |->
         red_ratio_out == function_latch_in[BC_RED_LSB +: BC_W])
      else $error("red ratio wrong");
   a_reset_clear:
      assert property ($fell(rst_in) |->
         grayscale_latch_out == '0 && !serial_out && !on_w)
      else $error("state not clear after reset");
endmodule // grayscale_pwm_latch_sva
bind grayscale_pwm_latch grayscale_pwm_latch_sva u_grayscale_pwm_latch_sva (
   .ref_clk_in, .rst_in, .serial_clk_in, .load_in, .pwm_reference_clock_in,
   .gate_in, .function_latch_in, .serial_out, .blue_sink_n_out,
   .red_sink_n_out, .blue_ratio_out, .red_ratio_out, .grayscale_latch_out);

// *** sim/host_model.sv ***
/* host model: serial port, reference clock and gate.
   assumes tasks are called just after a rising clk_in edge. */
`timescale 1ns/1ps
module host_model (
   input wire logic clk_in,
   output logic sclk_out = 1'b0,
   output logic sdata_out = 1'b0,
   output logic load_out = 1'b0,
   output logic gref_out = 1'b0,
   output logic gate_out = 1'b0
);
   // ****
   // pin tasks, each level held two clocks so the edge is seen
   // ****
   task automatic shift_bit(input logic b);
      sdata_out <= b;
      sclk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      sclk_out <= 1'b0;
      sdata_out <= ~b; // data line not held once the clock drops
      repeat (2) @(posedge clk_in);
   endtask
   // callers need not drop the gate; t_live loads with the gate high
   task automatic load_pulse();
      load_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      load_out <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
   task automatic ref_pulse();
      gref_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      gref_out <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
   task automatic set_gate(input logic g);
      gate_out <= g;
      repeat (2) @(posedge clk_in);
   endtask
endmodule // host_model

// *** sim/grayscale_pwm_latch_tb_top.sv ***
/* self-checking bench for grayscale_pwm_latch.
   assumes host_model drives serial port, reference clock and gate. */
`timescale 1ns/1ps
`define CHK(g, e) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("Error %0t got %h exp %h", $time, g, e); \
   end \
end
module grayscale_pwm_latch_tb_top;
   import pwm_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [FBD_W-1:0] fl_r = {41{5'b10110}};
   logic [FBD_W-1:0] fl_old = '0;
   logic [GS_BITS-1:0] prev = '0;
   logic [GS_BITS-1:0] latch;
   logic sclk, sdata, load, gref, gate, so;
   logic [CH_N-1:0] blue, red;
   logic [BC_W-1:0] bra, rra;
   int err_count = 0;
   int n_compared = 0;
   // ****
   // clock, partner, design
   // ****
   always #12.5 ref_clk_in = ~ref_clk_in;
   host_model u_host_model (.clk_in(ref_clk_in), .sclk_out(sclk),
      .sdata_out(sdata), .load_out(load), .gref_out(gref), .gate_out(gate));
   grayscale_pwm_latch u_grayscale_pwm_latch (.ref_clk_in, .rst_in,
      .serial_clk_in(sclk), .serial_data_in(sdata), .load_in(load),
      .pwm_reference_clock_in(gref), .gate_in(gate),
      .function_latch_in(fl_r), .serial_out(so), .blue_sink_n_out(blue),
      .red_sink_n_out(red), .blue_ratio_out(bra), .red_ratio_out(rra),
      .grayscale_latch_out(latch));
   // blue k at 36k+24, red k at 36k, reserved slots filled
   function automatic logic [GS_BITS-1:0] mk(input logic [11:0] b, r);
      logic [GS_BITS-1:0] f;
      f = {24{12'ha5a}};
      for (int k = 0; k < 8; k++) begin
         f[36*k+24 +: 12] = b + 12'(k);
         f[36*k +: 12] = r + 12'(k);
      end
      return f;
   endfunction
   function automatic logic [15:0] exp_on(input logic [1:0] md, int c);
      logic [11:0] m;
      logic [15:0] s;
      m = !md[1] ? 12'hfff : (md[0] ? 12'h0ff : 12'h3ff);
      for (int k = 0; k < 8; k++) begin
         s[k+8] = c >= 1 && c <= int'(prev[36*k+24 +: 12] & m);
         s[k] = c >= 1 && c <= int'(prev[36*k +: 12] & m);
      end
      return s;
   endfunction
   // ****
   // scenarios
   // ****
   // old contents leave on serial_out while the new frame shifts in
   task automatic t_frame(input logic [GS_BITS-1:0] f);
      logic [GS_BITS-1:0] ov;
      ov = {prev[287:205], fl_old};
      for (int i = 287; i >= 0; i--) begin
         #1 `CHK(so, ov[i])
         @(posedge ref_clk_in);
         u_host_model.shift_bit(f[i]);
      end
      fl_old = fl_r;
      u_host_model.load_pulse();
      #1 `CHK(latch, f)
      prev = f;
      @(posedge ref_clk_in);
   endtask
   task automatic t_pwm(input logic [1:0] md);
      fl_r[198:197] <= md;
      fl_r[191:184] <= 8'h3c ^ {6'h0, md};
      u_host_model.set_gate(1'b1);
      #1 `CHK({bra, rra, blue, red}, {8'h3c ^ {6'h0, md}, 8'h5a, 16'h0})
      for (int c = 1; c <= 9; c++) begin
         @(posedge ref_clk_in);
         u_host_model.ref_pulse();
         #1 `CHK({blue, red}, exp_on(md, c))
      end
      @(posedge ref_clk_in);
      u_host_model.set_gate(1'b0);
      u_host_model.ref_pulse();
      #1 `CHK({blue, red}, 16'h0)
      @(posedge ref_clk_in);
   endtask
   // reload with the gate high: sinks follow without a new period
   task automatic t_live();
      fl_r[198:197] <= 2'b00;
      u_host_model.set_gate(1'b1);
      repeat (3) u_host_model.ref_pulse();
      t_frame(mk(12'h000, 12'h004));
      #1 `CHK({blue, red}, exp_on(2'b00, 3))
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      #1 `CHK({latch, so, blue, red}, '0)
      @(posedge ref_clk_in);
      t_frame(mk(12'h400, 12'h100));
      for (int m = 0; m < 4; m++) t_pwm(2'(m));
      t_live();
      tally_and_finish();
   end
   // about 3100 cycles are needed; give over six times that
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      err_count++;
      tally_and_finish();
   end
endmodule // grayscale_pwm_latch_tb_top
